// ==== crx_pkg.sv ====
// shared constants for the can receive fifo release and write guard ends
package crx_pkg;
  // device register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // device register offsets
  localparam logic [3:0] ADR_MASTER_CTRL   = 4'h0;
  localparam logic [3:0] ADR_MASTER_STATUS = 4'h1;
  localparam logic [3:0] ADR_RX_FIFO       = 4'h2;
  localparam logic [3:0] ADR_RX_MAILBOX    = 4'h3;
  localparam logic [3:0] ADR_BIT_TIMING_LO = 4'h4;
  localparam logic [3:0] ADR_BIT_TIMING_HI = 4'h5;
  localparam logic [3:0] ADR_FILTER_CFG_A  = 4'h6;
  localparam logic [3:0] ADR_FILTER_CFG_B  = 4'h7;
  localparam logic [3:0] ADR_FILTER_MODE   = 4'h8;
  localparam logic [3:0] ADR_DIAGNOSIS     = 4'h9;
  localparam logic [3:0] ADR_FILTER_ACTIVE = 4'hA;
  localparam logic [3:0] ADR_FILTER_VAL_0  = 4'hB;
  localparam logic [3:0] ADR_FILTER_VAL_1  = 4'hC;
  localparam logic [3:0] ADR_TX_CTRL       = 4'hD;
  localparam logic [3:0] ADR_TX_MAILBOX    = 4'hE;
  // field positions
  localparam int INIT_REQUEST_BIT     = 0;
  localparam int INIT_ACK_BIT         = 0;
  localparam int RECEIVING_BIT        = 5;
  localparam int RELEASE_BIT          = 5;
  localparam int RX_LEVEL_BIT         = 3;
  localparam int TX_REQUEST_BIT       = 0;
  localparam logic [7:0] PENDING_MASK = 8'h03;
  localparam logic [1:0] CRITICAL_PENDING = 2'h2;
  localparam logic [1:0] FIFO_DEPTH   = 2'h3;
  // reset values
  localparam logic [7:0] CFG_RESET    = 8'h00;
  // bus timing in can bit times, one bit time at the top baud rate in cpu cycles
  localparam int BIT_CYCLES      = 8;
  localparam int SAMPLE_CYCLES   = 4;
  localparam int XFER_BITS       = 6;
  localparam int END_BITS        = 8;
  localparam int SYNC_BITS       = 11;
  localparam logic [6:0] XFER_CYC = 7'(XFER_BITS * BIT_CYCLES + SAMPLE_CYCLES);
  localparam logic [6:0] END_CYC  = 7'(END_BITS * BIT_CYCLES);
  localparam logic [6:0] SYNC_CYC = 7'(SYNC_BITS * BIT_CYCLES);
  // host avalon register map, byte addresses
  localparam logic [3:0] AVS_CMD    = 4'h0;
  localparam logic [3:0] AVS_STATUS = 4'h4;
  localparam int CMD_DATA_LSB  = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_READ_BIT  = 17;
  localparam int CMD_SAFE_BIT  = 18;
  localparam int STAT_BUSY_BIT = 8;
endpackage

// ==== crx_bus_if.sv ====
// register port between the cpu side and the can controller
`timescale 1ns/1ns
`default_nettype none
interface crx_bus_if;
  logic                      wr;
  logic                      rd;
  logic [crx_pkg::ADDR_W-1:0] addr;
  logic [crx_pkg::DATA_W-1:0] wdata;
  logic [crx_pkg::DATA_W-1:0] rdata;
  logic                      rvalid;
  modport dev  (input wr, rd, addr, wdata, output rdata, rvalid);
  modport host (output wr, rd, addr, wdata, input rdata, rvalid);
endinterface
`default_nettype wire

// ==== crx_dev_end.sv ====
// can controller end: write guard, receive observer and three level receive fifo
`timescale 1ns/1ns
`default_nettype none
module crx_dev_end (
  // clock, reset, enable
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clk_en,
  // register port
  crx_bus_if.dev                bus,
  // can receive pin
  input  wire logic             i_can_rx,
  // status
  output logic                  o_init_mode,
  output logic [1:0]            o_pending_count,
  output logic                  o_receiving
);

  // next slot index in a three level ring
  function automatic logic [1:0] slot_next(input logic [1:0] p);
    slot_next = (p == 2'h2) ? 2'h0 : p + 2'h1;
  endfunction

  logic       rx_meta_q;
  logic       rx_sync_q;
  logic [6:0] run_q;
  logic       receiving_q;
  logic       init_req_q;
  logic       init_ack_q;
  logic [7:0] bt_lo_q;
  logic [7:0] bt_hi_q;
  logic [7:0] fcfg_a_q;
  logic [7:0] fcfg_b_q;
  logic [7:0] fmode_q;
  logic [7:0] diag_q;
  logic [1:0] fact_q;
  logic [7:0] fval_q [0:1];
  logic       tx_pend_q;
  logic [7:0] tx_mb_q;
  logic [7:0] fifo_q [0:2];
  logic [1:0] wr_ptr_q;
  logic [1:0] rd_ptr_q;
  logic [1:0] count_q;
  logic [7:0] seq_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic [7:0] rdata_d;
  logic       xfer;
  logic       frame_end;
  logic       push;
  logic       pop;
  logic       cfg_wr;

  // frame timing seen from the rx pin
  assign xfer      = receiving_q && (run_q == crx_pkg::XFER_CYC);
  assign frame_end = receiving_q && (run_q == crx_pkg::END_CYC);
  assign push      = xfer && (count_q != crx_pkg::FIFO_DEPTH);
  assign pop       = bus.wr && (bus.addr == crx_pkg::ADR_RX_FIFO)
                     && bus.wdata[crx_pkg::RELEASE_BIT] && (count_q != 2'h0);
  assign cfg_wr    = bus.wr && init_ack_q;

  // two stage synchroniser, idle bus is recessive
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end
    else if (i_clk_en)
    begin
      rx_meta_q <= i_can_rx;
      rx_sync_q <= rx_meta_q;
    end
  end

  // recessive run length in cycles, saturates at the resync length
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      run_q <= 7'h00;
    else if (i_clk_en)
    begin
      if (!rx_sync_q)
        run_q <= 7'h00;
      else if (run_q != crx_pkg::SYNC_CYC)
        run_q <= run_q + 7'h01;
    end
  end

  // receiving flag: dominant starts a frame, long recessive run ends it
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
      receiving_q <= 1'b0;
    else if (i_clk_en)
    begin
      if (!rx_sync_q)
        receiving_q <= 1'b1;
      else if (frame_end)
        receiving_q <= 1'b0;
    end
  end

  // init request and acknowledge handshake
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      init_req_q <= 1'b0;
      init_ack_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (bus.wr && (bus.addr == crx_pkg::ADR_MASTER_CTRL))
        init_req_q <= bus.wdata[crx_pkg::INIT_REQUEST_BIT];
      if (init_req_q && !receiving_q && rx_sync_q)
        init_ack_q <= 1'b1;
      else if (!init_req_q && (run_q == crx_pkg::SYNC_CYC))
        init_ack_q <= 1'b0;
    end
  end

  // guarded configuration registers
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      bt_lo_q  <= crx_pkg::CFG_RESET;
      bt_hi_q  <= crx_pkg::CFG_RESET;
      fcfg_a_q <= crx_pkg::CFG_RESET;
      fcfg_b_q <= crx_pkg::CFG_RESET;
      fmode_q  <= crx_pkg::CFG_RESET;
      diag_q   <= crx_pkg::CFG_RESET;
    end
    else if (i_clk_en && cfg_wr)
    begin
      unique case (bus.addr)
        crx_pkg::ADR_BIT_TIMING_LO: bt_lo_q  <= bus.wdata;
        crx_pkg::ADR_BIT_TIMING_HI: bt_hi_q  <= bus.wdata;
        crx_pkg::ADR_FILTER_CFG_A:  fcfg_a_q <= bus.wdata;
        crx_pkg::ADR_FILTER_CFG_B:  fcfg_b_q <= bus.wdata;
        crx_pkg::ADR_FILTER_MODE:   fmode_q  <= bus.wdata;
        crx_pkg::ADR_DIAGNOSIS:     diag_q   <= bus.wdata;
        default: ;
      endcase
    end
  end

  // filter activation and filter values, value locked while active
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      fact_q    <= 2'h0;
      fval_q[0] <= crx_pkg::CFG_RESET;
      fval_q[1] <= crx_pkg::CFG_RESET;
    end
    else if (i_clk_en && bus.wr)
    begin
      if (bus.addr == crx_pkg::ADR_FILTER_ACTIVE)
        fact_q <= bus.wdata[1:0];
      if ((bus.addr == crx_pkg::ADR_FILTER_VAL_0) && !fact_q[0])
        fval_q[0] <= bus.wdata;
      if ((bus.addr == crx_pkg::ADR_FILTER_VAL_1) && !fact_q[1])
        fval_q[1] <= bus.wdata;
    end
  end

  // transmit mailbox, pending until the next frame on the bus ends
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      tx_pend_q <= 1'b0;
      tx_mb_q   <= crx_pkg::CFG_RESET;
    end
    else if (i_clk_en)
    begin
      if (bus.wr && (bus.addr == crx_pkg::ADR_TX_MAILBOX) && !tx_pend_q)
        tx_mb_q <= bus.wdata;
      if (bus.wr && (bus.addr == crx_pkg::ADR_TX_CTRL)
          && bus.wdata[crx_pkg::TX_REQUEST_BIT])
        tx_pend_q <= 1'b1;
      else if (frame_end)
        tx_pend_q <= 1'b0;
    end
  end

  // fifo storage, message content is a frame sequence number
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      seq_q     <= 8'h00;
      fifo_q[0] <= 8'h00;
      fifo_q[1] <= 8'h00;
      fifo_q[2] <= 8'h00;
    end
    else if (i_clk_en && xfer)
    begin
      seq_q <= seq_q + 8'h01;
      if (push)
        fifo_q[wr_ptr_q] <= seq_q;
    end
  end

  // fifo pointers and count move independently, so release and fill may coincide
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      count_q  <= 2'h0;
    end
    else if (i_clk_en)
    begin
      if (push)
        wr_ptr_q <= slot_next(wr_ptr_q);
      if (pop)
        rd_ptr_q <= slot_next(rd_ptr_q);
      unique case ({push, pop})
        2'b10:   count_q <= count_q + 2'h1;
        2'b01:   count_q <= count_q - 2'h1;
        default: count_q <= count_q;
      endcase
    end
  end

  // read multiplexer
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (bus.addr)
      crx_pkg::ADR_MASTER_CTRL:   rdata_d[crx_pkg::INIT_REQUEST_BIT] = init_req_q;
      crx_pkg::ADR_MASTER_STATUS:
      begin
        rdata_d[crx_pkg::INIT_ACK_BIT]  = init_ack_q;
        rdata_d[crx_pkg::RECEIVING_BIT] = receiving_q;
      end
      crx_pkg::ADR_RX_FIFO:       rdata_d[1:0] = count_q;
      crx_pkg::ADR_RX_MAILBOX:    rdata_d = fifo_q[rd_ptr_q];
      crx_pkg::ADR_BIT_TIMING_LO: rdata_d = bt_lo_q;
      crx_pkg::ADR_BIT_TIMING_HI: rdata_d = bt_hi_q;
      crx_pkg::ADR_FILTER_CFG_A:  rdata_d = fcfg_a_q;
      crx_pkg::ADR_FILTER_CFG_B:  rdata_d = fcfg_b_q;
      crx_pkg::ADR_FILTER_MODE:   rdata_d = fmode_q;
      crx_pkg::ADR_DIAGNOSIS:
      begin
        rdata_d = diag_q;
        rdata_d[crx_pkg::RX_LEVEL_BIT] = rx_sync_q;
      end
      crx_pkg::ADR_FILTER_ACTIVE: rdata_d[1:0] = fact_q;
      crx_pkg::ADR_FILTER_VAL_0:  rdata_d = fval_q[0];
      crx_pkg::ADR_FILTER_VAL_1:  rdata_d = fval_q[1];
      crx_pkg::ADR_TX_CTRL:       rdata_d[crx_pkg::TX_REQUEST_BIT] = tx_pend_q;
      crx_pkg::ADR_TX_MAILBOX:    rdata_d = tx_mb_q;
      default:                    rdata_d = 8'h00;
    endcase
  end

  // registered read answer one cycle after the strobe, plus status outputs
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      rdata_q         <= 8'h00;
      rvalid_q        <= 1'b0;
      o_init_mode     <= 1'b0;
      o_pending_count <= 2'h0;
      o_receiving     <= 1'b0;
    end
    else if (i_clk_en)
    begin
      rvalid_q        <= bus.rd;
      if (bus.rd)
        rdata_q <= rdata_d;
      o_init_mode     <= init_ack_q;
      o_pending_count <= count_q;
      o_receiving     <= receiving_q;
    end
  end

  assign bus.rdata  = rdata_q;
  assign bus.rvalid = rvalid_q;

endmodule // crx_dev_end
`default_nettype wire

// ==== crx_host_end.sv ====
// cpu side end: avalon slave that runs raw accesses and the safe fifo release
`timescale 1ns/1ns
`default_nettype none
module crx_host_end (
  // clock, reset, enable
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  // device register port
  crx_bus_if.host          bus,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);

  typedef enum logic [2:0] {
    H_IDLE, H_RAW_WAIT, H_CNT_WAIT, H_REC_WAIT, H_PIN_WAIT
  } crx_host_state_type;

  crx_host_state_type state_q;
  logic        go_q;
  logic [18:0] cmd_q;
  logic [7:0]  last_q;
  logic        wr_q;
  logic        rd_q;
  logic [3:0]  addr_q;
  logic [7:0]  wdata_q;
  logic        busy;
  logic        cmd_wr;
  logic        accept;

  assign busy   = go_q || (state_q != H_IDLE);
  assign cmd_wr = i_avs_write && (i_avs_address == crx_pkg::AVS_CMD);
  assign accept = o_avs_waitrequest && (i_avs_read || i_avs_write) && !(cmd_wr && busy);

  // avalon slave: one wait cycle, longer for a command write while a command is still running
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
      go_q              <= 1'b0;
      cmd_q             <= 19'h0_0000;
    end
    else if (i_clk_en)
    begin
      o_avs_waitrequest <= !accept;
      go_q              <= accept && cmd_wr;
      if (accept && cmd_wr)
        cmd_q <= i_avs_writedata[18:0];
      if (accept && i_avs_read)
        o_avs_readdata <= (i_avs_address == crx_pkg::AVS_STATUS)
                          ? {23'h00_0000, busy, last_q} : 32'h0000_0000;
    end
  end

  // device access sequencer, never interleaves a raw access into the release check
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      state_q <= H_IDLE;
      last_q  <= 8'h00;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= 4'h0;
      wdata_q <= 8'h00;
    end
    else if (i_clk_en)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      unique case (state_q)
        H_IDLE:
          if (go_q)
          begin
            if (cmd_q[crx_pkg::CMD_SAFE_BIT])
            begin
              rd_q    <= 1'b1;
              addr_q  <= crx_pkg::ADR_RX_FIFO;
              state_q <= H_CNT_WAIT;
            end
            else
            begin
              addr_q  <= cmd_q[3:0];
              wdata_q <= cmd_q[crx_pkg::CMD_DATA_LSB +: 8];
              wr_q    <= cmd_q[crx_pkg::CMD_WRITE_BIT];
              rd_q    <= cmd_q[crx_pkg::CMD_READ_BIT];
              if (cmd_q[crx_pkg::CMD_READ_BIT])
                state_q <= H_RAW_WAIT;
            end
          end
        H_RAW_WAIT:
          if (bus.rvalid)
          begin
            last_q  <= bus.rdata;
            state_q <= H_IDLE;
          end
        H_CNT_WAIT, H_REC_WAIT, H_PIN_WAIT:
          if (bus.rvalid)
          begin
            last_q <= bus.rdata;
            if (((state_q == H_CNT_WAIT)
                 && ((bus.rdata & crx_pkg::PENDING_MASK) != 8'(crx_pkg::CRITICAL_PENDING)))
                || ((state_q == H_REC_WAIT) && !bus.rdata[crx_pkg::RECEIVING_BIT])
                || ((state_q == H_PIN_WAIT) && !bus.rdata[crx_pkg::RX_LEVEL_BIT]))
            begin
              wr_q    <= 1'b1;
              addr_q  <= crx_pkg::ADR_RX_FIFO;
              wdata_q <= 8'(1 << crx_pkg::RELEASE_BIT);
              state_q <= H_IDLE;
            end
            else if (state_q == H_REC_WAIT)
            begin
              rd_q    <= 1'b1;
              addr_q  <= crx_pkg::ADR_DIAGNOSIS;
              state_q <= H_PIN_WAIT;
            end
            else
            begin
              rd_q    <= 1'b1;
              addr_q  <= crx_pkg::ADR_MASTER_STATUS;
              state_q <= H_REC_WAIT;
            end
          end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign bus.wr    = wr_q;
  assign bus.rd    = rd_q;
  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;

endmodule // crx_host_end
`default_nettype wire

// ==== crx_monitor.sv ====
// assertion checker on the register port and receive status between the two ends
`timescale 1ns/1ns
`default_nettype none
module crx_monitor (
  // clock and reset
  input wire logic                       i_clock,
  input wire logic                       i_sys_rst,
  // register port
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [crx_pkg::ADDR_W-1:0] addr,
  input wire logic [crx_pkg::DATA_W-1:0] rdata,
  input wire logic                       rvalid,
  // pin and status
  input wire logic                       i_can_rx,
  input wire logic                       o_init_mode,
  input wire logic [1:0]                 o_pending_count,
  input wire logic                       o_receiving
);
  logic [7:0] rec_run_q;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // length of the present recessive run on the pin, saturating
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst || !i_can_rx)
      rec_run_q <= 8'h00;
    else if (rec_run_q != 8'hff)
      rec_run_q <= rec_run_q + 8'h01;
  end
  chk_read_answer: assert property (rd |=> rvalid)
    else $error("read got no answer");
  chk_answer_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  chk_strobe_excl: assert property (!(wr && rd))
    else $error("read and write together");
  chk_count_field: assert property (rd && addr == crx_pkg::ADR_RX_FIFO
    |=> rdata == {6'h00, o_pending_count}) else $error("pending field wrong");
  chk_pin_level: assert property (rd && addr == crx_pkg::ADR_DIAGNOSIS && $stable(i_can_rx)
    && i_can_rx == $past(i_can_rx, 2) && i_can_rx == $past(i_can_rx, 3)
    |=> rdata[crx_pkg::RX_LEVEL_BIT] == $past(i_can_rx)) else $error("pin level wrong");
  chk_pend_step: assert property (2'(o_pending_count - $past(o_pending_count)) != 2'h2)
    else $error("pending count jumped");
  chk_xfer_time: assert property (o_pending_count == $past(o_pending_count) + 2'h1
    |-> rec_run_q >= 8'h34 && rec_run_q <= 8'h40) else $error("transfer at wrong time");
  chk_rx_start: assert property ($fell(i_can_rx) && !o_init_mode
    |-> ##[1:6] o_receiving) else $error("receiving flag missing");
  chk_rx_hold: assert property (o_receiving && rec_run_q < 8'h3c |=> o_receiving)
    else $error("receiving flag dropped early");
  chk_rx_end: assert property (rec_run_q == 8'h48 |-> !o_receiving)
    else $error("receiving flag stuck");
  chk_init_idle: assert property ($rose(o_init_mode)
    |-> !o_receiving && !$past(o_receiving)) else $error("init entered while receiving");
endmodule  // crx_monitor
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for both ends joined over the register port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        i_clock = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        can_rx = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        init_mode;
  logic [1:0]  pend_count;
  logic        receiving;
  logic        note_rd = 1'b0;
  logic [31:0] got;
  logic [15:0] ent;
  logic [15:0] exp_q[$];
  logic [7:0]  cfg[16] = '{default: 8'h00};
  logic [7:0]  seq0;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          dly;
  crx_bus_if crx_bus_if_i ();
  crx_dev_end crx_dev_end_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
    .bus(crx_bus_if_i), .i_can_rx(can_rx), .o_init_mode(init_mode),
    .o_pending_count(pend_count), .o_receiving(receiving));
  crx_host_end crx_host_end_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
    .bus(crx_bus_if_i), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest));
  crx_monitor crx_monitor_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .wr(crx_bus_if_i.wr), .rd(crx_bus_if_i.rd), .addr(crx_bus_if_i.addr),
    .rdata(crx_bus_if_i.rdata), .rvalid(crx_bus_if_i.rvalid), .i_can_rx(can_rx),
    .o_init_mode(init_mode), .o_pending_count(pend_count), .o_receiving(receiving));
  // 25 MHz clock
  always #20 i_clock = ~i_clock;
  task automatic give_verdict();
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c);
    @(posedge i_clock);
    note_rd <= c;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do
    begin
      @(posedge i_clock);
    end
    while (avs_waitrequest !== 1'b0);
    got = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // command write, then poll until the host end is idle
  task automatic cmd(input logic [31:0] c);
    avs(1'b1, crx_pkg::AVS_CMD, c, 1'b0);
    do
    begin
      avs(1'b0, crx_pkg::AVS_STATUS, 32'h0000_0000, 1'b0);
    end
    while (got[crx_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic dev_wr(input logic [3:0] a, input logic [7:0] d);
    cmd(32'(1 << crx_pkg::CMD_WRITE_BIT) | {16'h0000, d, 4'h0, a});
  endtask
  // raw device read; the byte is noted for the monitor with a mask
  task automatic dev_rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    cmd(32'(1 << crx_pkg::CMD_READ_BIT) | {28'h000_0000, a});
    exp_q.push_back({m, e});
    avs(1'b0, crx_pkg::AVS_STATUS, 32'h0000_0000, 1'b1);
  endtask
  // guarded registers: stored only when open, pin bit of diagnosis masked
  task automatic guard(input logic open);
    for (int a = 4; a < 10; a++)
    begin
      if (open)
        cfg[a] = 8'($urandom);
      dev_wr(4'(a), open ? cfg[a] : ~cfg[a]);
      dev_rd(4'(a), cfg[a], (a == 9) ? 8'hf7 : 8'hff);
    end
  endtask
  // frame of eight-cycle bits, ack at bit nine, then twelve recessive bits
  task automatic frame();
    logic [3:0] run;
    logic       b;
    run = 4'h0;
    for (int i = 0; i < 22; i++)
    begin
      b = (i == 0 || i == 9) ? 1'b0 : (i > 9) ? 1'b1 : 1'($urandom);
      if (i < 9 && run == 4'h4)
        b = 1'b0;
      run = b ? run + 4'h1 : 4'h0;
      @(posedge i_clock);
      can_rx <= b;
      repeat (7) @(posedge i_clock);
    end
  endtask
  // compares each noted read with the oldest expectation
  always @(posedge i_clock)
  begin
    if (avs_read && avs_waitrequest === 1'b0 && note_rd && exp_q.size() > 0)
    begin
      ent = exp_q.pop_front();
      check(avs_readdata[7:0] & ent[15:8], ent[7:0] & ent[15:8]);
    end
  end
  // watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge i_clock);
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'he89f));
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    guard(1'b0);
    dev_wr(4'hf, 8'h5a);
    dev_rd(4'hf, 8'h00, 8'hff);
    dev_rd(crx_pkg::ADR_DIAGNOSIS, 8'h08, 8'h08);
    dev_wr(crx_pkg::ADR_MASTER_CTRL, 8'h01);
    dev_rd(crx_pkg::ADR_MASTER_STATUS, 8'h01, 8'h01);
    guard(1'b1);
    dev_wr(crx_pkg::ADR_MASTER_CTRL, 8'h00);
    frame();
    dev_rd(crx_pkg::ADR_MASTER_STATUS, 8'h00, 8'h01);
    guard(1'b0);
    dev_wr(crx_pkg::ADR_FILTER_ACTIVE, 8'h01);
    dev_wr(crx_pkg::ADR_FILTER_VAL_0, 8'h33);
    dev_wr(crx_pkg::ADR_FILTER_VAL_1, 8'h44);
    dev_rd(crx_pkg::ADR_FILTER_VAL_0, 8'h00, 8'hff);
    dev_rd(crx_pkg::ADR_FILTER_VAL_1, 8'h44, 8'hff);
    dev_wr(crx_pkg::ADR_FILTER_ACTIVE, 8'h00);
    dev_wr(crx_pkg::ADR_FILTER_VAL_0, 8'h33);
    dev_rd(crx_pkg::ADR_FILTER_VAL_0, 8'h33, 8'hff);
    dev_wr(crx_pkg::ADR_TX_MAILBOX, 8'h11);
    dev_wr(crx_pkg::ADR_TX_CTRL, 8'h01);
    dev_wr(crx_pkg::ADR_TX_MAILBOX, 8'h77);
    dev_rd(crx_pkg::ADR_TX_MAILBOX, 8'h11, 8'hff);
    dev_rd(crx_pkg::ADR_TX_CTRL, 8'h01, 8'h01);
    frame();
    dev_rd(crx_pkg::ADR_TX_CTRL, 8'h00, 8'h01);
    dev_wr(crx_pkg::ADR_TX_MAILBOX, 8'h77);
    dev_rd(crx_pkg::ADR_TX_MAILBOX, 8'h77, 8'hff);
    repeat (3) dev_wr(crx_pkg::ADR_RX_FIFO, 8'h20);
    dev_rd(crx_pkg::ADR_RX_FIFO, 8'h00, 8'hff);
    can_rx <= 1'b0;
    dev_rd(crx_pkg::ADR_MASTER_STATUS, 8'h20, 8'h20);
    dev_rd(crx_pkg::ADR_DIAGNOSIS, 8'h00, 8'h08);
    can_rx <= 1'b1;
    repeat (100) @(posedge i_clock);
    dev_rd(crx_pkg::ADR_MASTER_STATUS, 8'h00, 8'h20);
    dev_rd(crx_pkg::ADR_RX_FIFO, 8'h01, 8'hff);
    frame();
    // oldest unreleased message is the third one received
    dev_rd(crx_pkg::ADR_RX_MAILBOX, 8'h02, 8'hff);
    seq0 = 8'h02;
    // release swept across the transfer cycle, then safe releases inside frames
    for (int i = 0; i < 20; i++)
    begin
      dly = (i < 14) ? 125 + i : 61 + 4 * (i - 14);
      fork
        frame();
        begin
          repeat (dly) @(posedge i_clock);
          if (i < 14)
            dev_wr(crx_pkg::ADR_RX_FIFO, 8'h20);
          else
            cmd(32'(1 << crx_pkg::CMD_SAFE_BIT));
        end
      join
      dev_rd(crx_pkg::ADR_RX_FIFO, 8'h02, 8'hff);
      dev_rd(crx_pkg::ADR_RX_MAILBOX, seq0 + 8'h01 + 8'(i), 8'hff);
    end
    frame();
    frame();
    dev_rd(crx_pkg::ADR_RX_FIFO, 8'h03, 8'hff);
    cmd(32'(1 << crx_pkg::CMD_SAFE_BIT));
    dev_wr(crx_pkg::ADR_RX_FIFO, 8'h20);
    dev_rd(crx_pkg::ADR_RX_MAILBOX, seq0 + 8'h16, 8'hff);
    repeat (2) dev_wr(crx_pkg::ADR_RX_FIFO, 8'h20);
    dev_rd(crx_pkg::ADR_RX_FIFO, 8'h00, 8'hff);
    // init request during a frame waits until the frame is over
    fork
      frame();
      begin
        repeat (20) @(posedge i_clock);
        dev_wr(crx_pkg::ADR_MASTER_CTRL, 8'h01);
        dev_rd(crx_pkg::ADR_MASTER_STATUS, 8'h20, 8'h21);
      end
    join
    dev_rd(crx_pkg::ADR_MASTER_STATUS, 8'h01, 8'h21);
    dev_wr(crx_pkg::ADR_MASTER_CTRL, 8'h00);
    dev_rd(crx_pkg::ADR_RX_FIFO, 8'h01, 8'hff);
    give_verdict();
  end
endmodule  // tb_top
`default_nettype wire
